// >>> core/dbgm_sideband.sv
// Debug sideband: comms full flags, keep-powered request, write gate and configuration readback
//
// Behaviour
// - comms_rx_full is 1 while the receive word holds data not yet read by software, else 0.
// - comms_tx_full is 1 while the transmit word holds data not yet read by the debugger, else 0.
// - keep_powered_request is high while the debugger has asked that the core stay powered.
// - With software_debug_write_enable low only the debugger may write the control register; high lets software too.
// - rom_table_base_in gives address bits 31 to 12 of the ROM table; bits 11 to 1 read as zero and bit 0 reads the valid qualifier.
// - debug_regs_offset_in gives bits 31 to 15 of a signed offset from the ROM table to the debug registers.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module dbgm_sideband (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire dbgm_pkg::dbgm_req_t sw_req,
    output logic [31:0] sw_rdata,
    input wire dbgm_pkg::dbgm_req_t dbg_req,
    output logic [31:0] dbg_rdata,
    input wire logic software_debug_write_enable,
    input wire dbgm_pkg::dbgm_cfg_t cfg,
    output logic comms_rx_full,
    output logic comms_tx_full,
    output logic keep_powered_request
);
    logic [dbgm_pkg::MB_COUNT-1:0] mb_wr;
    logic [dbgm_pkg::MB_COUNT-1:0] mb_take;
    logic [dbgm_pkg::MB_COUNT-1:0] mb_full;
    logic [31:0] mb_wdata [dbgm_pkg::MB_COUNT];
    logic [31:0] mb_data [dbgm_pkg::MB_COUNT];
    logic sw_blocked;
    logic sw_ctl_wr;
    logic dbg_ctl_wr;
    logic blocked_clr;
    logic [31:0] status_word;
    logic [31:0] rom_word;
    logic [31:0] ofs_word;
    logic [31:0] next_sw_rdata;
    logic [31:0] next_dbg_rdata;

    // Receive half: debugger fills, software read drains
    assign mb_wr[dbgm_pkg::MB_RX] = dbg_req.wr && (dbg_req.addr == dbgm_pkg::OFF_DCC_RX);
    assign mb_wdata[dbgm_pkg::MB_RX] = dbg_req.wdata;
    assign mb_take[dbgm_pkg::MB_RX] = sw_req.rd && (sw_req.addr == dbgm_pkg::OFF_DCC_RX);
    // Transmit half: software fills, debugger read drains
    assign mb_wr[dbgm_pkg::MB_TX] = sw_req.wr && (sw_req.addr == dbgm_pkg::OFF_DCC_TX);
    assign mb_wdata[dbgm_pkg::MB_TX] = sw_req.wdata;
    assign mb_take[dbgm_pkg::MB_TX] = dbg_req.rd && (dbg_req.addr == dbgm_pkg::OFF_DCC_TX);

    generate
        for (genvar i = 0; i < dbgm_pkg::MB_COUNT; i++) begin : g_mb
            dbgm_mailbox u_mb (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .wr_en(mb_wr[i]),
                .wr_data(mb_wdata[i]),
                .take(mb_take[i]),
                .full(mb_full[i]),
                .data(mb_data[i])
            );
        end
    endgenerate

    assign comms_rx_full = mb_full[dbgm_pkg::MB_RX];
    assign comms_tx_full = mb_full[dbgm_pkg::MB_TX];

    // Control register writes; software is gated by the enable input
    assign dbg_ctl_wr = dbg_req.wr && (dbg_req.addr == dbgm_pkg::OFF_CONTROL);
    assign sw_ctl_wr = sw_req.wr && (sw_req.addr == dbgm_pkg::OFF_CONTROL) && software_debug_write_enable;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            keep_powered_request <= dbgm_pkg::RST_KEEP_PWR;
        end else if (dbg_ctl_wr) begin
            // Debugger wins a same-cycle collision with software
            keep_powered_request <= dbg_req.wdata[dbgm_pkg::CTL_KEEP_PWR];
        end else if (sw_ctl_wr) begin
            keep_powered_request <= sw_req.wdata[dbgm_pkg::CTL_KEEP_PWR];
        end
    end

    // Sticky record of a refused software write; write one to clear, a new refusal wins
    assign blocked_clr = (sw_req.wr && (sw_req.addr == dbgm_pkg::OFF_STATUS) && sw_req.wdata[dbgm_pkg::ST_SW_BLOCKED])
        || (dbg_req.wr && (dbg_req.addr == dbgm_pkg::OFF_STATUS) && dbg_req.wdata[dbgm_pkg::ST_SW_BLOCKED]);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sw_blocked <= dbgm_pkg::RST_BLOCKED;
        end else if (sw_req.wr && (sw_req.addr == dbgm_pkg::OFF_CONTROL) && !software_debug_write_enable) begin
            sw_blocked <= 1'b1;
        end else if (blocked_clr) begin
            sw_blocked <= 1'b0;
        end
    end

    // Configuration values read as zero unless qualified
    always_comb begin
        rom_word = 32'h0000_0000;
        ofs_word = 32'h0000_0000;
        if (cfg.rom_valid) begin
            rom_word[31:dbgm_pkg::ROM_LSB] = cfg.rom_base;
        end
        rom_word[dbgm_pkg::CFG_VALID_BIT] = cfg.rom_valid;
        if (cfg.offset_valid) begin
            ofs_word[31:dbgm_pkg::OFS_LSB] = cfg.regs_offset;
        end
        ofs_word[dbgm_pkg::CFG_VALID_BIT] = cfg.offset_valid;
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[dbgm_pkg::ST_RX_FULL] = mb_full[dbgm_pkg::MB_RX];
        status_word[dbgm_pkg::ST_TX_FULL] = mb_full[dbgm_pkg::MB_TX];
        status_word[dbgm_pkg::ST_KEEP_PWR] = keep_powered_request;
        status_word[dbgm_pkg::ST_SW_EN] = software_debug_write_enable;
        status_word[dbgm_pkg::ST_ROM_VALID] = cfg.rom_valid;
        status_word[dbgm_pkg::ST_OFS_VALID] = cfg.offset_valid;
        status_word[dbgm_pkg::ST_SW_BLOCKED] = sw_blocked;
    end

    function automatic logic [31:0] read_mux(
        input logic [7:0] addr,
        input logic [31:0] st,
        input logic [31:0] rx,
        input logic [31:0] tx,
        input logic kp,
        input logic [31:0] rom,
        input logic [31:0] ofs
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        case (addr)
            dbgm_pkg::OFF_ID: r = dbgm_pkg::ID_VALUE;
            dbgm_pkg::OFF_DCC_RX: r = rx;
            dbgm_pkg::OFF_DCC_TX: r = tx;
            dbgm_pkg::OFF_STATUS: r = st;
            dbgm_pkg::OFF_CONTROL: r = {31'h0000_0000, kp};
            dbgm_pkg::OFF_ROM_BASE: r = rom;
            dbgm_pkg::OFF_REGS_OFFSET: r = ofs;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    always_comb begin
        next_sw_rdata = 32'h0000_0000;
        next_dbg_rdata = 32'h0000_0000;
        if (sw_req.rd) begin
            next_sw_rdata = read_mux(sw_req.addr, status_word, mb_data[dbgm_pkg::MB_RX],
                mb_data[dbgm_pkg::MB_TX], keep_powered_request, rom_word, ofs_word);
        end
        if (dbg_req.rd) begin
            next_dbg_rdata = read_mux(dbg_req.addr, status_word, mb_data[dbgm_pkg::MB_RX],
                mb_data[dbgm_pkg::MB_TX], keep_powered_request, rom_word, ofs_word);
        end
    end

    // Read data stand one cycle only, zero otherwise
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sw_rdata <= dbgm_pkg::RST_DATA;
            dbg_rdata <= dbgm_pkg::RST_DATA;
        end else begin
            sw_rdata <= next_sw_rdata;
            dbg_rdata <= next_dbg_rdata;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_rx_fill;
        mb_wr[dbgm_pkg::MB_RX] && !comms_rx_full |=> comms_rx_full;
    endproperty
    a_rx_fill: assert property (p_rx_fill) else $error("receive flag not set by debugger write");

    property p_rx_drain;
        mb_take[dbgm_pkg::MB_RX] && !mb_wr[dbgm_pkg::MB_RX] |=> !comms_rx_full;
    endproperty
    a_rx_drain: assert property (p_rx_drain) else $error("receive flag not cleared by software read");

    property p_rx_hold;
        comms_rx_full && !mb_take[dbgm_pkg::MB_RX] |=> comms_rx_full && $stable(mb_data[dbgm_pkg::MB_RX]);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("unread receive word lost");

    property p_tx_fill;
        mb_wr[dbgm_pkg::MB_TX] && !comms_tx_full
            |=> comms_tx_full && mb_data[dbgm_pkg::MB_TX] == $past(sw_req.wdata);
    endproperty
    a_tx_fill: assert property (p_tx_fill) else $error("transmit flag not set by software write");

    property p_tx_drain;
        mb_take[dbgm_pkg::MB_TX] && !mb_wr[dbgm_pkg::MB_TX] && comms_tx_full
            |=> !comms_tx_full && dbg_rdata == $past(mb_data[dbgm_pkg::MB_TX]);
    endproperty
    a_tx_drain: assert property (p_tx_drain) else $error("debugger read of transmit word wrong");

    property p_keep_pwr;
        dbg_ctl_wr |=> keep_powered_request == $past(dbg_req.wdata[dbgm_pkg::CTL_KEEP_PWR]);
    endproperty
    a_keep_pwr: assert property (p_keep_pwr) else $error("keep-powered request not following debugger");

    property p_sw_blocked;
        sw_req.wr && sw_req.addr == dbgm_pkg::OFF_CONTROL && !software_debug_write_enable && !dbg_ctl_wr
            |=> $stable(keep_powered_request) && sw_blocked;
    endproperty
    a_sw_blocked: assert property (p_sw_blocked) else $error("software changed control while disabled");

    property p_rom_read;
        sw_req.rd && sw_req.addr == dbgm_pkg::OFF_ROM_BASE
            |=> sw_rdata[11:1] == 11'h000 && sw_rdata[0] == $past(cfg.rom_valid)
            && sw_rdata[31:12] == ($past(cfg.rom_valid) ? $past(cfg.rom_base) : 20'h0_0000);
    endproperty
    a_rom_read: assert property (p_rom_read) else $error("ROM table address readback wrong");

    property p_ofs_read;
        dbg_req.rd && dbg_req.addr == dbgm_pkg::OFF_REGS_OFFSET
            |=> dbg_rdata[14:1] == 14'h0000 && dbg_rdata[0] == $past(cfg.offset_valid)
            && dbg_rdata[31:15] == ($past(cfg.offset_valid) ? $past(cfg.regs_offset) : 17'h0_0000);
    endproperty
    a_ofs_read: assert property (p_ofs_read) else $error("debug register offset readback wrong");

    property p_rdata_idle;
        !sw_req.rd ##1 1'b1 |-> sw_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("software read data outside its cycle");

    // Drain hands over the word held before any same-cycle refill
    property p_rx_read;
        mb_take[dbgm_pkg::MB_RX] |=> sw_rdata == $past(mb_data[dbgm_pkg::MB_RX]);
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("software read of receive word wrong");

    property p_tx_hold;
        comms_tx_full && !mb_take[dbgm_pkg::MB_TX] |=> comms_tx_full && $stable(mb_data[dbgm_pkg::MB_TX]);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("unread transmit word lost");

    property p_kp_stable;
        !dbg_ctl_wr && !sw_ctl_wr |=> $stable(keep_powered_request);
    endproperty
    a_kp_stable: assert property (p_kp_stable) else $error("keep-powered request moved without a write");

    property p_sw_allowed;
        sw_ctl_wr && !dbg_ctl_wr |=> keep_powered_request == $past(sw_req.wdata[dbgm_pkg::CTL_KEEP_PWR]);
    endproperty
    a_sw_allowed: assert property (p_sw_allowed) else $error("enabled software control write not applied");

    property p_blocked_hold;
        sw_blocked && !blocked_clr |=> sw_blocked;
    endproperty
    a_blocked_hold: assert property (p_blocked_hold) else $error("refusal record lost without a clear");

    c_rx_round: cover property (mb_wr[dbgm_pkg::MB_RX] ##[1:20] mb_take[dbgm_pkg::MB_RX]);
    c_tx_round: cover property (mb_wr[dbgm_pkg::MB_TX] ##[1:20] mb_take[dbgm_pkg::MB_TX]);
    c_blocked: cover property (sw_blocked && !software_debug_write_enable);
    c_fill_drain_same: cover property (mb_wr[dbgm_pkg::MB_RX] && mb_take[dbgm_pkg::MB_RX] && comms_rx_full);
endmodule

// >>> common/dbgm_pkg.sv
// Shared constants and carrier types for the debug sideband block
package dbgm_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_ID = 8'h00;
    localparam logic [7:0] OFF_DCC_RX = 8'h04;
    localparam logic [7:0] OFF_DCC_TX = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_ROM_BASE = 8'h14;
    localparam logic [7:0] OFF_REGS_OFFSET = 8'h18;

    // Arbitrary identification value
    localparam logic [31:0] ID_VALUE = 32'h0000_D5B1;

    // Status bit positions
    localparam int ST_RX_FULL = 0;
    localparam int ST_TX_FULL = 1;
    localparam int ST_KEEP_PWR = 2;
    localparam int ST_SW_EN = 3;
    localparam int ST_ROM_VALID = 4;
    localparam int ST_OFS_VALID = 5;
    localparam int ST_SW_BLOCKED = 6;

    // Control bit positions
    localparam int CTL_KEEP_PWR = 0;

    // Address layouts
    localparam int ROM_LSB = 12;
    localparam int OFS_LSB = 15;
    localparam int CFG_VALID_BIT = 0;

    // Values after reset
    localparam logic RST_FULL = 1'b0;
    localparam logic RST_KEEP_PWR = 1'b0;
    localparam logic RST_BLOCKED = 1'b0;
    localparam logic [31:0] RST_DATA = 32'h0000_0000;

    // Mailbox halves
    localparam int MB_RX = 0;
    localparam int MB_TX = 1;
    localparam int MB_COUNT = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dbgm_req_t;

    typedef struct packed {
        logic [31:ROM_LSB] rom_base;
        logic rom_valid;
        logic [31:OFS_LSB] regs_offset;
        logic offset_valid;
    } dbgm_cfg_t;

endpackage

// >>> core/dbgm_mailbox.sv
// One half of the debug communications data register: a single word with a full flag
`timescale 1ns/1ps
module dbgm_mailbox (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    input wire logic take,
    output logic full,
    output logic [31:0] data
);
    logic accept;

    // A write to a full word is dropped unless the reader empties it in the same cycle
    assign accept = wr_en && (!full || take);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            full <= dbgm_pkg::RST_FULL;
        end else if (accept) begin
            // Fill wins over a drain in the same cycle
            full <= 1'b1;
        end else if (take) begin
            full <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            data <= dbgm_pkg::RST_DATA;
        end else if (accept) begin
            data <= wr_data;
        end
    end
endmodule

// >>> dv/dbgm_far_model.sv
// Far-side model: external debugger port and system configuration straps
`timescale 1ns/1ps
module dbgm_far_model (
    input wire logic clk_sys,
    input wire logic [31:0] dbg_rdata,
    output dbgm_pkg::dbgm_req_t dbg_req,
    output dbgm_pkg::dbgm_cfg_t cfg
);
    initial begin
        dbg_req = '0;
        cfg = '0;
    end

    // Idle bus shows inverted leftovers so a stale sample cannot pass
    task automatic release_bus();
        dbg_req.addr <= ~dbg_req.addr;
        dbg_req.wdata <= ~dbg_req.wdata;
        dbg_req.wr <= 1'b0;
        dbg_req.rd <= 1'b0;
    endtask

    task automatic write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        dbg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        release_bus();
    endtask

    task automatic read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        dbg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        release_bus();
        #1;
        d = dbg_rdata;
    endtask

    // Unknown values are strapped low together with their qualifier
    task automatic set_cfg(input logic rom_ok, input logic [19:0] rom, input logic ofs_ok, input logic [16:0] ofs);
        @(posedge clk_sys);
        cfg.rom_base <= rom_ok ? rom : 20'h00000;
        cfg.rom_valid <= rom_ok;
        cfg.regs_offset <= ofs_ok ? ofs : 17'h00000;
        cfg.offset_valid <= ofs_ok;
    endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the debug sideband block
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    dbgm_pkg::dbgm_req_t sw_req = '0;
    dbgm_pkg::dbgm_req_t dbg_req;
    dbgm_pkg::dbgm_cfg_t cfg;
    logic [31:0] sw_rdata;
    logic [31:0] dbg_rdata;
    logic software_debug_write_enable = 1'b0;
    logic comms_rx_full;
    logic comms_tx_full;
    logic keep_powered_request;
    int bad_count = 0;
    int n_checks = 0;

    always #4 clk_sys = ~clk_sys;

    dbgm_sideband dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sw_req(sw_req),
        .sw_rdata(sw_rdata),
        .dbg_req(dbg_req),
        .dbg_rdata(dbg_rdata),
        .software_debug_write_enable(software_debug_write_enable),
        .cfg(cfg),
        .comms_rx_full(comms_rx_full),
        .comms_tx_full(comms_tx_full),
        .keep_powered_request(keep_powered_request)
    );

    dbgm_far_model far (
        .clk_sys(clk_sys),
        .dbg_rdata(dbg_rdata),
        .dbg_req(dbg_req),
        .cfg(cfg)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        sw_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        sw_req <= '0;
    endtask

    task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        sw_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        sw_req <= '0;
        #1;
        d = sw_rdata;
    endtask

    task automatic test_reset();
        #1;
        chk({29'h0, comms_rx_full, comms_tx_full, keep_powered_request}, 32'h0, "outputs after reset");
        $display("test reset done");
    endtask

    task automatic test_rx();
        logic [31:0] v;
        far.write(dbgm_pkg::OFF_DCC_RX, 32'hA5C3_0F81);
        #1;
        chk(32'(comms_rx_full), 32'h1, "rx full after fill");
        far.write(dbgm_pkg::OFF_DCC_RX, 32'h1111_2222);
        sw_read(dbgm_pkg::OFF_DCC_RX, v);
        chk(v, 32'hA5C3_0F81, "rx word, second fill dropped");
        chk(32'(comms_rx_full), 32'h0, "rx empty after drain");
        far.write(dbgm_pkg::OFF_DCC_RX, 32'h3C96_E10D);
        // Refill and drain land on the same edge
        fork
            far.write(dbgm_pkg::OFF_DCC_RX, 32'h7E81_24DB);
            sw_read(dbgm_pkg::OFF_DCC_RX, v);
        join
        chk(v, 32'h3C96_E10D, "rx word drained with refill");
        chk(32'(comms_rx_full), 32'h1, "rx full kept by same-cycle refill");
        sw_read(dbgm_pkg::OFF_DCC_RX, v);
        chk(v, 32'h7E81_24DB, "rx refill word");
        chk(32'(comms_rx_full), 32'h0, "rx empty after second drain");
        $display("test rx done");
    endtask

    task automatic test_tx();
        logic [31:0] v;
        sw_write(dbgm_pkg::OFF_DCC_TX, 32'h5A3C_F07E);
        #1;
        chk(32'(comms_tx_full), 32'h1, "tx full after fill");
        sw_read(dbgm_pkg::OFF_DCC_TX, v);
        chk(v, 32'h5A3C_F07E, "tx word seen by software");
        chk(32'(comms_tx_full), 32'h1, "tx kept after software look");
        far.read(dbgm_pkg::OFF_DCC_TX, v);
        chk(v, 32'h5A3C_F07E, "tx word at debugger");
        chk(32'(comms_tx_full), 32'h0, "tx empty after drain");
        $display("test tx done");
    endtask

    task automatic test_power_gate();
        logic [31:0] v;
        far.write(dbgm_pkg::OFF_CONTROL, 32'h0000_0001);
        #1;
        chk(32'(keep_powered_request), 32'h1, "keep powered raised");
        @(posedge clk_sys);
        software_debug_write_enable <= 1'b0;
        sw_write(dbgm_pkg::OFF_CONTROL, 32'h0000_0000);
        #1;
        chk(32'(keep_powered_request), 32'h1, "blocked software write");
        sw_read(dbgm_pkg::OFF_STATUS, v);
        chk(v & 32'h0000_004F, 32'h0000_0044, "status sticky block and power");
        sw_write(dbgm_pkg::OFF_STATUS, 32'h0000_0040);
        software_debug_write_enable <= 1'b1;
        sw_write(dbgm_pkg::OFF_CONTROL, 32'h0000_0000);
        #1;
        chk(32'(keep_powered_request), 32'h0, "allowed software write");
        sw_read(dbgm_pkg::OFF_STATUS, v);
        chk(v & 32'h0000_004F, 32'h0000_0008, "status after allowed write");
        $display("test power and gate done");
    endtask

    task automatic test_cfg();
        logic [31:0] v;
        far.set_cfg(1'b1, 20'hABCDE, 1'b1, 17'h1FFF0);
        sw_read(dbgm_pkg::OFF_ROM_BASE, v);
        chk(v, 32'hABCD_E001, "rom base with valid");
        far.read(dbgm_pkg::OFF_REGS_OFFSET, v);
        chk(v, 32'hFFF8_0001, "negative offset with valid");
        sw_read(dbgm_pkg::OFF_STATUS, v);
        chk(v & 32'h0000_0030, 32'h0000_0030, "both valids reported");
        far.set_cfg(1'b0, 20'hABCDE, 1'b0, 17'h1FFF0);
        sw_read(dbgm_pkg::OFF_ROM_BASE, v);
        chk(v, 32'h0, "rom base unknown");
        sw_read(dbgm_pkg::OFF_REGS_OFFSET, v);
        chk(v, 32'h0, "offset unknown");
        sw_read(dbgm_pkg::OFF_STATUS, v);
        chk(v & 32'h0000_0030, 32'h0, "valids low reported");
        sw_read(8'h1C, v);
        chk(v, 32'h0, "unmapped read");
        $display("test config done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        test_reset();
        test_rx();
        test_tx();
        test_power_gate();
        test_cfg();
        complete_run();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #20000;
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
